// >>> prx_defines.vh
// prx_defines.vh: register offsets, field positions, reset values and timing counts
// assumes a 125 MHz ref_clk; included by every design file of the block
`ifndef PRX_DEFINES_VH
`define PRX_DEFINES_VH
`define PRX_ADDR_ENABLE 8'h00
`define PRX_ADDR_WAIT_TIME_FIELD 8'h03
`define PRX_ADDR_PILTL 8'h08
`define PRX_ADDR_PILTH 8'h09
`define PRX_ADDR_PIHTL 8'h0A
`define PRX_ADDR_PIHTH 8'h0B
`define PRX_ADDR_PERS 8'h0C
`define PRX_ADDR_CONFIG 8'h0D
`define PRX_ADDR_PULSE 8'h0E
`define PRX_ADDR_CONTROL 8'h0F
`define PRX_ADDR_ID 8'h12
`define PRX_ADDR_STATUS 8'h13
`define PRX_ADDR_PROX_RESULT_LOW 8'h18
`define PRX_ADDR_PROX_RESULT_HIGH 8'h19
`define PRX_CMD_SEL 7
`define PRX_CMD_TYPE_HI 6
`define PRX_CMD_TYPE_LO 5
`define PRX_CMD_AUTOINC 2'b01
`define PRX_CMD_SPECIAL 2'b11
`define PRX_CMD_CLR_PROX 5'h05
`define PRX_BIT_WAIT_LONG_BIT 1
`define PRX_BIT_PROX_INTERRUPT_ENABLE 5
`define PRX_BIT_PROX_INTERRUPT_FLAG 5
`define PRX_DRIVE_HI 7
`define PRX_DRIVE_LO 6
`define PRX_DIODE_HI 5
`define PRX_DIODE_LO 4
`define PRX_PERS_HI 7
`define PRX_PERS_LO 4
`define PRX_RST_BYTE 8'h00
`define PRX_RST_WAIT_TIME_FIELD 8'hFF
`define PRX_RST_DIODE_CTRL 8'h20
`define PRX_WAIT_LONG_MULT 12
`define PRX_WAIT_STEP_NS 2720000
`define PRX_CLK_NS 8
`define PRX_PULSE_HZ 62500
`define PRX_CLK_HZ 125000000
`endif

// >>> prx_host.sv
// prx_host.sv: i2c master model standing in for the host processor
// assumes open-drain sda with pull-up; scl stands high between frames
`timescale 1ns/1ns
module prx_host (
  // device drive
  input wire sda_oe_n,
  // bus pins and read results
  output logic scl,
  output wire sda,
  output logic rd_stb,
  output logic [7:0] rd_byte
);
  logic sda_q = 1'b1;
  // pull-up wins only when nobody pulls low
  assign sda = sda_q & sda_oe_n;
  initial begin
    scl = 1'b1;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
  end
  // one bit at a 125 ns period, entered and left with scl low
  task automatic clk_bit(input logic b, output logic r);
    #31 sda_q = b;
    #32 scl = 1'b1;
    #31 r = sda;
    #31 scl = 1'b0;
  endtask
  // start, or repeated start when rep is set
  task automatic go(input logic rep);
    if (rep) begin
      #31 sda_q = 1'b1;
      #32 scl = 1'b1;
    end
    #31 sda_q = 1'b0;
    #31 scl = 1'b0;
  endtask
  // stop, leaving both lines released
  task automatic halt();
    #31 sda_q = 1'b0;
    #32 scl = 1'b1;
    #31 sda_q = 1'b1;
    #62;
  endtask
  // byte out; ack is the level the device left on the ninth bit
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask
  // byte in; mack low acknowledges, high ends the read
  task automatic get(input logic mack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(mack, r);
    rd_byte = d;
    rd_stb = 1'b1;
    #8 rd_stb = 1'b0;
  endtask
endmodule // prx_host

// >>> prx_i2c_slave.v
// prx_i2c_slave.v: i2c target front end, byte-level register port
// assumes scl/sda sampled on ref_clk with two flops; open-drain sda, oe low drives low
`timescale 1ns/1ns
`include "prx_defines.vh"
module prx_i2c_slave #(
  parameter [6:0] DEV_ADDR = 7'h39
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire clk_en,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n_q,
  // byte port
  output reg wr_stb_q,
  output reg [7:0] wr_data_q,
  output reg start_stb_q,
  output reg rd_stb_q,
  input wire [7:0] rd_data
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_RACK = 3'd4;
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg addr_ph_q;
  reg rw_q;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  assign sda_out = 1'b0;
  assign scl_rise = scl_s_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_s_q[1] & scl_p_q;
  assign start_c = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop_c = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
  // synchronisers and edge history
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  // byte engine: address, ack, data in and out
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      addr_ph_q <= 1'b0;
      rw_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      wr_stb_q <= 1'b0;
      wr_data_q <= 8'h00;
      start_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else if (clk_en) begin
      wr_stb_q <= 1'b0;
      start_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (start_c) begin
        st_q <= ST_RX;
        bit_q <= 4'h0;
        addr_ph_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
        start_stb_q <= 1'b1;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
      end else begin
        case (st_q)
          ST_IDLE: sda_oe_n_q <= 1'b1;
          ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (addr_ph_q) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  rw_q <= sh_q[0];
                  sda_oe_n_q <= 1'b0;
                  st_q <= ST_ACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                wr_data_q <= sh_q;
                wr_stb_q <= 1'b1;
                sda_oe_n_q <= 1'b0;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              addr_ph_q <= 1'b0;
              if (rw_q) begin
                sh_q <= rd_data;
                rd_stb_q <= 1'b1;
                sda_oe_n_q <= rd_data[7];
                bit_q <= 4'h1;
                st_q <= ST_TX;
              end else begin
                sda_oe_n_q <= 1'b1;
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_oe_n_q <= 1'b1;
                st_q <= ST_RACK;
              end else begin
                sda_oe_n_q <= sh_q[3'd7 - bit_q[2:0]];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st_q <= sda_s_q[1] ? ST_IDLE : ST_ACK;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // prx_i2c_slave

// >>> prx_led_pulser.v
// prx_led_pulser.v: emits a burst of ir led pulses at the pulse rate
// assumes start is a one-cycle pulse on ref_clk
`timescale 1ns/1ns
`include "prx_defines.vh"
module prx_led_pulser #(
  parameter integer PERIOD_CYC = `PRX_CLK_HZ / `PRX_PULSE_HZ
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire clk_en,
  // control
  input wire start,
  input wire [7:0] count,
  output wire busy,
  // led
  output reg led_on_q
);
  reg [7:0] left_q;
  reg [11:0] cyc_q;
  assign busy = (left_q != 8'h00);
  // one pulse per period, high for the first half
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      left_q <= 8'h00;
      cyc_q <= 12'h000;
      led_on_q <= 1'b0;
    end else if (clk_en) begin
      if (start && !busy) begin
        left_q <= count;
        cyc_q <= 12'h000;
        led_on_q <= (count != 8'h00);
      end else if (busy) begin
        if (cyc_q == PERIOD_CYC[11:0] - 12'h1) begin
          cyc_q <= 12'h000;
          left_q <= left_q - 8'h01;
          led_on_q <= (left_q != 8'h01);
        end else begin
          cyc_q <= cyc_q + 12'h001;
          if (cyc_q == PERIOD_CYC[12:1] - 12'h1) led_on_q <= 1'b0;
        end
      end
    end
  end
endmodule // prx_led_pulser

// >>> prx_regs.v
// prx_regs.v: proximity sensor register bank, wait timer, pulse burst, interrupt
// assumes i2c pins sampled on ref_clk (125 MHz); adc result arrives on ref_clk
`timescale 1ns/1ns
`include "prx_defines.vh"
module prx_regs #(
  parameter [7:0] PART_ID = 8'h5A, // arbitrary identification value
  parameter [6:0] DEV_ADDR = 7'h39,
  parameter integer WAIT_STEP_CYC = `PRX_WAIT_STEP_NS / `PRX_CLK_NS
) (
  // clock, enable, reset
  input wire ref_clk,
  input wire clk_en,
  input wire arst_n,
  // i2c pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  // interrupt pin, open drain
  output wire int_out,
  output wire int_oe_n,
  // adc side
  output wire meas_start,
  input wire meas_done,
  input wire [15:0] meas_result,
  // analog controls
  output wire led_on,
  output reg [1:0] led_drive_strength,
  output reg [1:0] photodiode_select
);
  reg [7:0] enable_q;
  reg [7:0] wait_time_field_q;
  reg [15:0] thr_low_q;
  reg [15:0] thr_high_q;
  reg [7:0] pers_q;
  reg wait_long_bit_q;
  reg [7:0] ir_pulse_count_field_q;
  reg [7:0] ctrl_q;
  reg [15:0] result_q;
  reg [7:0] shadow_q;
  reg prox_interrupt_flag_q;
  reg [3:0] oor_cnt_q;
  reg [7:0] ptr_q;
  reg autoinc_q;
  reg first_q;
  reg [7:0] rd_data;
  reg [1:0] st_q;
  reg [31:0] wcyc_q;
  reg [11:0] wstep_q;
  reg start_q;
  reg [7:0] res_hi_prev_q; // high byte one cycle back, matches the low byte in flight
  wire wr_stb;
  wire [7:0] wr_data;
  wire start_stb;
  wire rd_stb;
  wire pulse_busy;
  wire oor;
  wire [3:0] prox_persistence;
  wire [8:0] wait_steps;
  wire [11:0] wait_total;
  wire below_low;
  wire above_high;
  wire meas_en;
  wire clr_prox;
  wire pers_met;
  localparam ST_OFF = 2'd0;
  localparam ST_PULSE = 2'd1;
  localparam ST_CONV = 2'd2;
  localparam ST_WAIT = 2'd3;
  // bus front end
  prx_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n_q(sda_oe_n),
    .wr_stb_q(wr_stb),
    .wr_data_q(wr_data),
    .start_stb_q(start_stb),
    .rd_stb_q(rd_stb),
    .rd_data(rd_data)
  );
  // led burst generator
  prx_led_pulser u_pulse (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .start(start_q),
    .count(ir_pulse_count_field_q),
    .busy(pulse_busy),
    .led_on_q(led_on)
  );
  assign prox_persistence = pers_q[`PRX_PERS_HI:`PRX_PERS_LO];
  // out of range on either side of the threshold window
  assign below_low = (result_q < thr_low_q);
  assign above_high = (result_q > thr_high_q);
  assign oor = below_low | above_high;
  // proximity cycle runs only with the oscillator on and both enable bits set
  assign meas_en = enable_q[0] && (enable_q[2:1] == 2'b11);
  // special command 0x05 clears the flag; only the first byte after a start is a command
  assign clr_prox = wr_stb && first_q && wr_data[`PRX_CMD_SEL] &&
                    (wr_data[`PRX_CMD_TYPE_HI:`PRX_CMD_TYPE_LO] == `PRX_CMD_SPECIAL) &&
                    (wr_data[4:0] == `PRX_CMD_CLR_PROX);
  // run length includes this result; one bit wider so a saturated count still compares
  assign pers_met = (prox_persistence == 4'h0) ||
                    (oor && ({1'b0, oor_cnt_q} + 5'h01 >= {1'b0, prox_persistence}));
  assign meas_start = start_q;
  // wait steps: 256 minus field, two's complement count
  assign wait_steps = 9'h100 - {1'b0, wait_time_field_q};
  assign wait_total = wait_long_bit_q ? ({3'b000, wait_steps} * 12'd`PRX_WAIT_LONG_MULT)
                                      : {3'b000, wait_steps};
  assign int_out = 1'b0;
  assign int_oe_n = ~prox_interrupt_flag_q;
  // analog control fields from control register
  always @* begin
    led_drive_strength = ctrl_q[`PRX_DRIVE_HI:`PRX_DRIVE_LO];
    photodiode_select = ctrl_q[`PRX_DIODE_HI:`PRX_DIODE_LO];
  end
  // read mux
  always @* begin
    case (ptr_q)
      `PRX_ADDR_ENABLE: rd_data = enable_q;
      `PRX_ADDR_WAIT_TIME_FIELD: rd_data = wait_time_field_q;
      `PRX_ADDR_PILTL: rd_data = thr_low_q[7:0];
      `PRX_ADDR_PILTH: rd_data = thr_low_q[15:8];
      `PRX_ADDR_PIHTL: rd_data = thr_high_q[7:0];
      `PRX_ADDR_PIHTH: rd_data = thr_high_q[15:8];
      `PRX_ADDR_PERS: rd_data = pers_q;
      `PRX_ADDR_CONFIG: rd_data = {6'h00, wait_long_bit_q, 1'b0};
      `PRX_ADDR_PULSE: rd_data = ir_pulse_count_field_q;
      `PRX_ADDR_CONTROL: rd_data = ctrl_q;
      `PRX_ADDR_ID: rd_data = PART_ID;
      `PRX_ADDR_STATUS: rd_data = {2'b00, prox_interrupt_flag_q, 5'h00};
      `PRX_ADDR_PROX_RESULT_LOW: rd_data = result_q[7:0];
      `PRX_ADDR_PROX_RESULT_HIGH: rd_data = shadow_q;
      default: rd_data = 8'h00;
    endcase
  end
  // command byte, register writes, pointer walk and shadow capture
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= `PRX_RST_BYTE;
      wait_time_field_q <= `PRX_RST_WAIT_TIME_FIELD;
      thr_low_q <= 16'h0000;
      thr_high_q <= 16'h0000;
      pers_q <= `PRX_RST_BYTE;
      wait_long_bit_q <= 1'b0;
      ir_pulse_count_field_q <= `PRX_RST_BYTE;
      ctrl_q <= `PRX_RST_DIODE_CTRL;
      shadow_q <= 8'h00;
      res_hi_prev_q <= 8'h00;
      ptr_q <= 8'h00;
      autoinc_q <= 1'b0;
      first_q <= 1'b0;
    end else if (clk_en) begin
      res_hi_prev_q <= result_q[15:8];
      if (start_stb) begin
        first_q <= 1'b1;
      end else if (wr_stb && first_q) begin
        first_q <= 1'b0;
        if (wr_data[`PRX_CMD_SEL]) begin
          ptr_q <= {3'b000, wr_data[4:0]};
          autoinc_q <= (wr_data[`PRX_CMD_TYPE_HI:`PRX_CMD_TYPE_LO] == `PRX_CMD_AUTOINC);
        end
      end else if (wr_stb) begin
        case (ptr_q)
          `PRX_ADDR_ENABLE: enable_q <= wr_data;
          `PRX_ADDR_WAIT_TIME_FIELD: wait_time_field_q <= wr_data;
          `PRX_ADDR_PILTL: thr_low_q[7:0] <= wr_data;
          `PRX_ADDR_PILTH: thr_low_q[15:8] <= wr_data;
          `PRX_ADDR_PIHTL: thr_high_q[7:0] <= wr_data;
          `PRX_ADDR_PIHTH: thr_high_q[15:8] <= wr_data;
          `PRX_ADDR_PERS: pers_q <= wr_data;
          `PRX_ADDR_CONFIG: wait_long_bit_q <= wr_data[`PRX_BIT_WAIT_LONG_BIT];
          `PRX_ADDR_PULSE: ir_pulse_count_field_q <= wr_data;
          `PRX_ADDR_CONTROL: ctrl_q <= wr_data;
          default: ctrl_q <= ctrl_q; // id, status, result ignore writes
        endcase
        if (autoinc_q) ptr_q <= ptr_q + 8'h01;
      end else if (rd_stb) begin
        if (ptr_q == `PRX_ADDR_PROX_RESULT_LOW) shadow_q <= res_hi_prev_q;
        if (autoinc_q) ptr_q <= ptr_q + 8'h01;
      end
    end
  end
  // measurement cycle: pulse burst, conversion, wait
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_OFF;
      start_q <= 1'b0;
      wcyc_q <= 32'h0;
      wstep_q <= 12'h000;
      result_q <= 16'h0000;
    end else if (clk_en) begin
      start_q <= 1'b0;
      case (st_q)
        ST_OFF: begin
          if (meas_en) begin
            start_q <= 1'b1;
            st_q <= ST_PULSE;
          end
        end
        ST_PULSE: if (!pulse_busy && !start_q) st_q <= ST_CONV;
        ST_CONV: begin
          if (meas_done) begin
            result_q <= meas_result;
            wcyc_q <= 32'h0;
            wstep_q <= 12'h000;
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!enable_q[3] || wstep_q == wait_total) begin
            st_q <= ST_OFF;
          end else if (wcyc_q == WAIT_STEP_CYC - 1) begin
            wcyc_q <= 32'h0;
            wstep_q <= wstep_q + 12'h001;
          end else begin
            wcyc_q <= wcyc_q + 32'h1;
          end
        end
        default: st_q <= ST_OFF;
      endcase
    end
  end
  // persistence filter and sticky interrupt flag
  reg done_q;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
      oor_cnt_q <= 4'h0;
      prox_interrupt_flag_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= (st_q == ST_CONV) && meas_done;
      if (done_q) begin
        if (!oor) oor_cnt_q <= 4'h0;
        else if (oor_cnt_q != 4'hF) oor_cnt_q <= oor_cnt_q + 4'h1;
      end
      // set wins over a clear in the same cycle
      if (done_q && enable_q[`PRX_BIT_PROX_INTERRUPT_ENABLE] && pers_met) begin
        prox_interrupt_flag_q <= 1'b1;
      end else if (clr_prox) begin
        prox_interrupt_flag_q <= 1'b0;
      end
    end
  end
endmodule // prx_regs

// >>> prx_regs_asserts.sv
// prx_regs_asserts.sv: port-level checks for the proximity register bank
// assumes a bind to prx_regs; one clock domain, ref_clk with async arst_n
`timescale 1ns/1ns
module prx_regs_asserts (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire clk_en,
  // i2c and interrupt pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire int_out,
  input wire int_oe_n,
  // adc side and analog controls
  input wire meas_start,
  input wire meas_done,
  input wire [15:0] meas_result,
  input wire led_on,
  input wire [1:0] led_drive_strength,
  input wire [1:0] photodiode_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  reg [11:0] hi_cnt_q;
  reg [8:0] idle_cnt_q;
  reg scl_last_q;
  // led pulse length so far, and cycles since scl last moved (saturating)
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_q <= 12'h000;
      idle_cnt_q <= 9'h000;
      scl_last_q <= 1'b1;
    end else begin
      hi_cnt_q <= led_on ? hi_cnt_q + 12'h001 : 12'h000;
      scl_last_q <= scl_in;
      idle_cnt_q <= (scl_in != scl_last_q) ? 9'h000 :
                    (idle_cnt_q == 9'h1FF) ? idle_cnt_q : idle_cnt_q + 9'h001;
    end
  end
  property p_meas_pulse; meas_start |=> !meas_start; endproperty
  a_meas_pulse: assert property (p_meas_pulse)
    else $error("start not a single cycle");
  property p_led_follow; meas_start |-> ##[0:3] led_on; endproperty
  a_led_follow: assert property (p_led_follow)
    else $error("burst did not follow start");
  property p_led_width; $fell(led_on) |-> hi_cnt_q == 12'h3E8; endproperty
  a_led_width: assert property (p_led_width)
    else $error("led pulse width wrong");
  property p_no_overlap; meas_start |-> !led_on; endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("start inside a burst");
  property p_int_cause; $fell(int_oe_n) |-> $past(meas_done, 2) || $past(meas_done, 3); endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt without a result");
  property p_int_clear; $rose(int_oe_n) |-> idle_cnt_q < 9'h0C8; endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt dropped without bus traffic");
  property p_ctrl_bus;
    $changed(photodiode_select) || $changed(led_drive_strength) |-> idle_cnt_q < 9'h0C8;
  endproperty
  a_ctrl_bus: assert property (p_ctrl_bus)
    else $error("analog control moved without a write");
  property p_sda_edge; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_sda_edge: assert property (p_sda_edge)
    else $error("data line moved with scl high");
  property p_od_level; sda_out == 1'b0 && int_out == 1'b0; endproperty
  a_od_level: assert property (p_od_level)
    else $error("open drain value not low");
endmodule // prx_regs_asserts
bind prx_regs prx_regs_asserts u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .int_out(int_out), .int_oe_n(int_oe_n), .meas_start(meas_start), .meas_done(meas_done),
  .meas_result(meas_result), .led_on(led_on), .led_drive_strength(led_drive_strength),
  .photodiode_select(photodiode_select));

// >>> prx_regs_tb.sv
// prx_regs_tb.sv: self-checking bench for the proximity register bank
// assumes prx_host as bus master and the bench itself as the adc
`timescale 1ns/1ns
module prx_regs_tb;
  localparam [7:0] ID_VAL = 8'hC3; // arbitrary identification value
  localparam [6:0] DEV = 7'h39;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic meas_done = 1'b0;
  logic [15:0] meas_result = 16'h0000;
  logic clk_en = 1'b1;
  wire scl, sda, sda_out, sda_oe_n, int_out, int_oe_n, meas_start, led_on, rd_stb;
  wire [7:0] rd_byte;
  wire [1:0] drv, dio;
  logic [7:0] exp_q[$];
  logic ack;
  logic [15:0] a, b;
  int n_errors = 0, checked = 0, n_led = 0, gap, i, j;
  always #4 ref_clk = ~ref_clk;
  prx_regs #(.PART_ID(ID_VAL), .WAIT_STEP_CYC(10)) dut (.ref_clk(ref_clk),
    .clk_en(clk_en), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n), .meas_start(meas_start),
    .meas_done(meas_done), .meas_result(meas_result), .led_on(led_on),
    .led_drive_strength(drv), .photodiode_select(dio));
  prx_host host (.sda_oe_n(sda_oe_n), .scl(scl), .sda(sda), .rd_stb(rd_stb), .rd_byte(rd_byte));
  // led pulses since the last start
  always @(posedge ref_clk) begin
    if (meas_start) n_led <= 0;
    else if ($rose(led_on)) n_led <= n_led + 1;
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // every byte read is matched against the oldest expectation
  always @(posedge rd_stb) chk({8'h00, rd_byte}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hXXXX);
  task automatic open_cmd(input logic [7:0] cmd);
    host.go(1'b0);
    host.put({DEV, 1'b0}, ack);
    chk(ack, 0);
    host.put(cmd, ack);
    chk(ack, 0);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    open_cmd(8'h80 | ad);
    host.put(d, ack);
    chk(ack, 0);
    host.halt();
  endtask
  task automatic rd_open(input logic [7:0] ad);
    open_cmd(8'hA0 | ad);
    host.go(1'b1);
    host.put({DEV, 1'b1}, ack);
    chk(ack, 0);
  endtask
  task automatic rd1(input logic [7:0] ad, input logic [7:0] e);
    rd_open(ad);
    exp_q.push_back(e);
    host.get(1'b1);
    host.halt();
  endtask
  // wait for a start, then let a two-pulse burst finish
  task automatic wait_burst();
    gap = 0;
    while (!meas_start && gap < 20000) begin
      @(posedge ref_clk);
      #1 gap++;
    end
    if (gap >= 20000) begin
      n_errors++;
      summarize();
    end
    repeat (4100) @(posedge ref_clk);
    chk(16'(n_led), 2);
  endtask
  task automatic cycle(input logic [15:0] r);
    @(posedge ref_clk) #1 meas_done = 1'b1;
    meas_result = r;
    @(posedge ref_clk) #1 meas_done = 1'b0;
    wait_burst();
  endtask
  initial begin
    #700000 n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(28825));
    repeat (20) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    // reset values, unmapped read, foreign address
    rd1(8'h0F, 8'h20);
    chk({drv, dio}, 4'h2);
    rd1(8'h0D, 8'h00);
    rd1(8'h1F, 8'h00);
    host.go(1'b0);
    host.put({7'h3A, 1'b0}, ack);
    chk(ack, 1);
    host.halt();
    // with the clock enable low the front end is frozen and stays silent
    @(posedge ref_clk) #1 clk_en = 1'b0;
    host.go(1'b0);
    host.put({DEV, 1'b0}, ack);
    chk(ack, 1);
    host.halt();
    @(posedge ref_clk) #1 clk_en = 1'b1;
    rd1(8'h0F, 8'h20);
    // read-only places ignore writes; control, pulse and config fields read back what was written
    wr(8'h12, ~ID_VAL);
    rd1(8'h12, ID_VAL);
    wr(8'h13, 8'hFF);
    rd1(8'h13, 8'h00);
    for (i = 0; i < 4; i++) begin
      for (j = 1; j < 4; j++) begin
        wr(8'h0F, {i[1:0], j[1:0], 4'h0});
        chk({drv, dio}, {i[1:0], j[1:0]});
        rd1(8'h0F, {i[1:0], j[1:0], 4'h0});
      end
    end
    a = 16'($urandom);
    wr(8'h0E, a[7:0]);
    rd1(8'h0E, a[7:0]);
    wr(8'h0D, {6'h00, a[8], 1'b0});
    rd1(8'h0D, {6'h00, a[8], 1'b0});
    // measurement with a two-step wait, persistence 0, thresholds 0
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h02);
    wr(8'h03, 8'hFE);
    wr(8'h00, 8'h2F);
    // the first start falls inside the enable write, so only the burst is awaited
    repeat (4100) @(posedge ref_clk);
    chk(16'(n_led), 2);
    a = 16'($urandom) | 16'h0001;
    cycle(a);
    chk(gap >= 20 && gap <= 28, 1);
    chk(int_oe_n, 0);
    rd1(8'h13, 8'h20);
    // a newer conversion lands between the two result bytes
    rd_open(8'h18);
    exp_q.push_back(a[7:0]);
    host.get(1'b0);
    b = 16'($urandom) | 16'h0001;
    cycle(b);
    exp_q.push_back(a[15:8]);
    host.get(1'b1);
    host.halt();
    rd_open(8'h18);
    exp_q.push_back(b[7:0]);
    exp_q.push_back(b[15:8]);
    host.get(1'b0);
    host.get(1'b1);
    host.halt();
    open_cmd(8'hE5);
    host.halt();
    chk(int_oe_n, 1);
    rd1(8'h13, 8'h00);
    // long wait and a persistence of two
    wr(8'h0D, 8'h02);
    wr(8'h0C, 8'h20);
    // an in-range result first ends the earlier run of out-of-range ones
    cycle(16'h0000);
    chk(gap >= 240 && gap <= 248, 1);
    chk(int_oe_n, 1);
    cycle(a);
    chk(int_oe_n, 1);
    cycle(b);
    chk(int_oe_n, 0);
    open_cmd(8'hE5);
    host.halt();
    // no interrupt with the enable bit clear
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h0F);
    cycle(a);
    chk(int_oe_n, 1);
    summarize();
  end
endmodule // prx_regs_tb
